/* File: inc/adc_seq_defs.vh */
// Overview of operation
// - Writing 1 to one-shot trigger starts one cycle; trigger bit self-clears.
// - Clearing enable lets a running cycle finish, then blocks new cycles.
// - One-shot and periodic cycles start only while enable is 1.
// - Enable going 0 to 1 sends a reset pulse to the converter core.
// - Period field [31:16] spaces periodic cycles in 40 us steps; zero starts the next cycle at once.
// - Writing periodic enable waits initial-delay field [15:0] steps before first cycle.
// - Delay fields do not affect one-shot cycles; they start at once.
// - Per-channel done flag set on completion; software clears it writing 1.
// - Mode done flag set after all enabled channels of that mode finish.
// - One-shot mask bit includes or excludes its channel in one-shot cycles.
// - Periodic mask bit includes or excludes its channel in each periodic pass.
// - Each of eight channels has its own result register, updated on conversion.
// - Result reads 10-bit value in low bits, upper 22 bits zero, read-only.
// - Done-flag bits of unimplemented channels are reserved.
// - Enabled channels convert in ascending order from the lowest one.
// - One-shot runs first when both pend; late request runs right after.
// - Mode done flags clear on write 1 and when their mode starts anew.
// - Clearing periodic enable keeps a running cycle but stops further ones.
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH

`define ADC_OFS_CTRL 6'h00
`define ADC_OFS_DELAY 6'h04
`define ADC_OFS_DONE 6'h08
`define ADC_OFS_ONESEL 6'h0C
`define ADC_OFS_PERSEL 6'h10
`define ADC_RES_IDX0 4'h5
`define ADC_RES_IDXN 4'hC

`define ADC_CTL_EN 0
`define ADC_CTL_ONE 1
`define ADC_CTL_PER 2
`define ADC_CTL_PSD 3
`define ADC_CTL_SRST 4
`define ADC_CTL_PDONE 6
`define ADC_CTL_ODONE 7

`define ADC_NCH 8
`define ADC_RES_W 10
`define ADC_CH_IMPL 8'hFF

`define ADC_STEP_TIME_NS 40000
`define ADC_CLK_PERIOD_NS 5
`define ADC_STEP_CYCLES (`ADC_STEP_TIME_NS / `ADC_CLK_PERIOD_NS)

`endif

/* File: core/adc_step_timer.v */
`timescale 1ns/100ps
`include "adc_seq_defs.vh"
module adc_step_timer #(
    parameter [15:0] STEP_CYCLES = `ADC_STEP_CYCLES
) (
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire run_i,
    input wire load_i,
    input wire [15:0] steps_i,
    output wire expire_o
);
    reg armed_q;
    reg expire_q;
    reg [15:0] left_q;
    reg [15:0] pre_q;

    assign expire_o = expire_q;

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            armed_q <= 1'b0;
            expire_q <= 1'b0;
            left_q <= 16'h0000;
            pre_q <= 16'h0000;
        end else if (!run_i) begin
            armed_q <= 1'b0;
            expire_q <= 1'b0;
        end else if (load_i) begin
            armed_q <= 1'b1;
            expire_q <= 1'b0;
            left_q <= steps_i;
            pre_q <= 16'h0000;
        end else if (armed_q) begin
            if (left_q == 16'h0000) begin
                expire_q <= 1'b1;
                armed_q <= 1'b0;
            end else if (pre_q == STEP_CYCLES - 16'h0001) begin
                pre_q <= 16'h0000;
                left_q <= left_q - 16'h0001;
                expire_q <= 1'b0;
            end else begin
                pre_q <= pre_q + 16'h0001;
                expire_q <= 1'b0;
            end
        end else begin
            expire_q <= 1'b0;
        end
    end
endmodule

/* File: core/adc_chan_pick.v */
`timescale 1ns/100ps
`include "adc_seq_defs.vh"
module adc_chan_pick (
    input wire [7:0] mask_i,
    input wire [3:0] from_i,
    output reg found_o,
    output reg [2:0] idx_o
);
    wire [7:0] elig;
    integer i;

    // Channels at or above the start point
    genvar g;
    generate
        for (g = 0; g < `ADC_NCH; g = g + 1) begin : g_elig
            localparam [3:0] IDX = g;
            assign elig[g] = mask_i[g] & (IDX >= from_i);
        end
    endgenerate

    always @* begin
        found_o = 1'b0;
        idx_o = 3'h0;
        for (i = `ADC_NCH - 1; i >= 0; i = i - 1) begin
            if (elig[i]) begin
                found_o = 1'b1;
                idx_o = i[2:0];
            end
        end
    end
endmodule

/* File: core/adc_conversion_sequencer.v */
`timescale 1ns/100ps
`include "adc_seq_defs.vh"
module adc_conversion_sequencer #(
    parameter [15:0] STEP_CYCLES = `ADC_STEP_CYCLES
) (
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire [5:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [3:0] reg_be_i,
    input wire [31:0] reg_wdata_i,
    output wire [31:0] reg_rdata_o,
    output wire conv_req_o,
    output wire [2:0] conv_chan_o,
    input wire core_done_i,
    input wire [9:0] core_data_i,
    output wire core_reset_o,
    output wire core_power_o,
    output wire oneshot_done_o,
    output wire periodic_done_o
);
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_REQ = 3'b010;
    localparam [2:0] S_ACK = 3'b100;

    // Control and configuration state
    reg en_q;
    reg per_q;
    reg psd_q;
    reg srst_q;
    reg one_pend_q;
    reg rep_pend_q;
    reg odone_q;
    reg pdone_q;
    reg per_load_q;
    reg [31:0] delay_q;
    reg [7:0] one_sel_q;
    reg [7:0] per_sel_q;
    reg [7:0] done_q;
    reg [`ADC_RES_W-1:0] res_q [0:`ADC_NCH-1];

    // Sequencer state
    reg [2:0] state_q;
    reg mode_q;
    reg [7:0] mask_q;
    reg [2:0] chan_q;
    reg req_q;
    reg core_rst_q;
    reg power_q;
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;

    // Done input synchroniser
    reg done_s1_q;
    reg done_s2_q;
    reg done_s3_q;
    reg done_lvl_q;

    wire [31:0] wd = reg_wdata_i;
    wire wr_ctrl;
    wire wr_delay;
    wire wr_done;
    wire wr_onesel;
    wire wr_persel;
    wire done_rise;
    wire st_idle;
    wire st_req;
    wire st_ack;
    wire can_start;
    wire start_one;
    wire start_per;
    wire got;
    wire ack_done;
    wire [7:0] pk_mask;
    wire [3:0] pk_from;
    wire pk_found;
    wire [2:0] pk_idx;
    wire last;
    wire fin_mode;
    wire one_fin;
    wire per_fin;
    wire tmr_load;
    wire [15:0] tmr_steps;
    wire tmr_expire;
    wire [7:0] ch_set;
    wire [3:0] res_idx;
    wire res_hit;
    wire [3:0] res_off;
    integer k;

    assign reg_rdata_o = rdata_q;
    assign conv_req_o = req_q;
    assign conv_chan_o = chan_q;
    assign core_reset_o = core_rst_q;
    assign core_power_o = power_q;
    assign oneshot_done_o = odone_q;
    assign periodic_done_o = pdone_q;

    // Register write decode, control bits in byte 0
    assign wr_ctrl = reg_wr_i & (reg_addr_i == `ADC_OFS_CTRL) & reg_be_i[0];
    assign wr_delay = reg_wr_i & (reg_addr_i == `ADC_OFS_DELAY);
    assign wr_done = reg_wr_i & (reg_addr_i == `ADC_OFS_DONE) & reg_be_i[0];
    assign wr_onesel = reg_wr_i & (reg_addr_i == `ADC_OFS_ONESEL) & reg_be_i[0];
    assign wr_persel = reg_wr_i & (reg_addr_i == `ADC_OFS_PERSEL) & reg_be_i[0];

    // Stable done edge after three stages
    assign done_rise = (done_s2_q == done_s3_q) & done_s3_q & ~done_lvl_q;

    assign st_idle = state_q[0];
    assign st_req = state_q[1];
    assign st_ack = state_q[2];

    assign can_start = st_idle & en_q & ~srst_q;
    assign start_one = can_start & one_pend_q;
    assign start_per = can_start & ~one_pend_q & rep_pend_q;
    assign got = st_req & done_rise;
    assign ack_done = st_ack & ~done_lvl_q & ~srst_q;

    assign pk_mask = st_idle ? (one_pend_q ? one_sel_q : per_sel_q) : mask_q;
    assign pk_from = st_idle ? 4'h0 : ({1'b0, chan_q} + 4'h1);

    adc_chan_pick u_pick (
        .mask_i(pk_mask),
        .from_i(pk_from),
        .found_o(pk_found),
        .idx_o(pk_idx)
    );

    // Cycle ends when no further channel remains
    assign last = ((start_one | start_per) | ack_done) & ~pk_found;
    assign fin_mode = st_idle ? start_per : mode_q;
    assign one_fin = last & ~fin_mode;
    assign per_fin = last & fin_mode;

    assign tmr_load = per_load_q | per_fin;
    assign tmr_steps = per_load_q ? delay_q[15:0] : delay_q[31:16];

    adc_step_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_timer (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .run_i(en_q & per_q),
        .load_i(tmr_load),
        .steps_i(tmr_steps),
        .expire_o(tmr_expire)
    );

    assign ch_set = got ? (8'h01 << chan_q) : 8'h00;

    // Result register index from address
    assign res_off = reg_addr_i[5:2];
    assign res_idx = res_off - `ADC_RES_IDX0;
    assign res_hit = (reg_addr_i[1:0] == 2'b00) & (res_off >= `ADC_RES_IDX0) & (res_off <= `ADC_RES_IDXN);

    // Three-stage synchroniser for core done
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
            done_s3_q <= 1'b0;
            done_lvl_q <= 1'b0;
        end else begin
            done_s1_q <= core_done_i;
            done_s2_q <= done_s1_q;
            done_s3_q <= done_s2_q;
            if (done_s2_q == done_s3_q) begin
                done_lvl_q <= done_s3_q;
            end
        end
    end

    // Software registers and request flags
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            en_q <= 1'b0;
            per_q <= 1'b0;
            psd_q <= 1'b0;
            srst_q <= 1'b0;
            one_pend_q <= 1'b0;
            rep_pend_q <= 1'b0;
            per_load_q <= 1'b0;
            core_rst_q <= 1'b0;
            delay_q <= 32'h0000_0000;
            one_sel_q <= 8'h00;
            per_sel_q <= 8'h00;
        end else begin
            if (wr_ctrl) begin
                en_q <= wd[`ADC_CTL_EN];
                per_q <= wd[`ADC_CTL_PER];
                psd_q <= wd[`ADC_CTL_PSD];
                srst_q <= wd[`ADC_CTL_SRST];
            end
            core_rst_q <= wr_ctrl & wd[`ADC_CTL_EN] & ~en_q;
            per_load_q <= wr_ctrl & wd[`ADC_CTL_PER];
            if (wr_ctrl & wd[`ADC_CTL_ONE] & wd[`ADC_CTL_EN]) begin
                one_pend_q <= 1'b1;
            end else if (start_one) begin
                one_pend_q <= 1'b0;
            end
            // pending periodic request clears with periodic enable off
            if (tmr_expire) begin
                rep_pend_q <= 1'b1;
            end else if (start_per | ~per_q) begin
                rep_pend_q <= 1'b0;
            end
            for (k = 0; k < 4; k = k + 1) begin
                if (wr_delay & reg_be_i[k]) begin
                    delay_q[k*8 +: 8] <= wd[k*8 +: 8];
                end
            end
            if (wr_onesel) begin
                one_sel_q <= wd[7:0];
            end
            if (wr_persel) begin
                per_sel_q <= wd[7:0];
            end
        end
    end

    // Done flags: hardware set wins over clear
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_q <= 8'h00;
            odone_q <= 1'b0;
            pdone_q <= 1'b0;
        end else begin
            done_q <= ((done_q & ~(wr_done ? wd[7:0] : 8'h00)) | ch_set) & `ADC_CH_IMPL;
            odone_q <= (odone_q & ~(wr_ctrl & wd[`ADC_CTL_ODONE]) & ~start_one) | one_fin;
            pdone_q <= (pdone_q & ~(wr_ctrl & wd[`ADC_CTL_PDONE]) & ~start_per) | per_fin;
        end
    end

    // Conversion sequencer
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= S_IDLE;
            mode_q <= 1'b0;
            mask_q <= 8'h00;
            chan_q <= 3'h0;
            req_q <= 1'b0;
        end else if (srst_q) begin
            state_q <= S_IDLE;
            req_q <= 1'b0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if ((start_one | start_per) & pk_found) begin
                        mode_q <= start_per;
                        mask_q <= pk_mask;
                        chan_q <= pk_idx;
                        req_q <= 1'b1;
                        state_q <= S_REQ;
                    end
                end
                S_REQ: begin
                    if (got) begin
                        req_q <= 1'b0;
                        state_q <= S_ACK;
                    end
                end
                S_ACK: begin
                    if (ack_done & pk_found) begin
                        chan_q <= pk_idx;
                        req_q <= 1'b1;
                        state_q <= S_REQ;
                    end else if (ack_done) begin
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                    req_q <= 1'b0;
                end
            endcase
        end
    end

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (k = 0; k < `ADC_NCH; k = k + 1) begin
                res_q[k] <= 10'h000;
            end
        end else if (got) begin
            res_q[chan_q] <= core_data_i;
        end
    end

    // power held until running cycle ends
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            power_q <= 1'b0;
        end else begin
            power_q <= (en_q & (psd_q | one_pend_q | rep_pend_q)) | ~st_idle;
        end
    end

    // Read data mux
    always @* begin
        rdata_d = 32'h0000_0000;
        case (reg_addr_i)
            `ADC_OFS_CTRL: begin
                rdata_d[`ADC_CTL_EN] = en_q;
                rdata_d[`ADC_CTL_ONE] = one_pend_q;
                rdata_d[`ADC_CTL_PER] = per_q;
                rdata_d[`ADC_CTL_PSD] = psd_q;
                rdata_d[`ADC_CTL_SRST] = srst_q;
                rdata_d[`ADC_CTL_PDONE] = pdone_q;
                rdata_d[`ADC_CTL_ODONE] = odone_q;
            end
            `ADC_OFS_DELAY: rdata_d = delay_q;
            `ADC_OFS_DONE: rdata_d[7:0] = done_q;
            `ADC_OFS_ONESEL: rdata_d[7:0] = one_sel_q;
            `ADC_OFS_PERSEL: rdata_d[7:0] = per_sel_q;
            default: begin
                if (res_hit) begin
                    rdata_d[`ADC_RES_W-1:0] = res_q[res_idx[2:0]];
                end
            end
        endcase
    end

    // Read data registered, whole word at once
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            rdata_q <= rdata_d;
        end
    end
endmodule

/* File: dv/adc_core_model.sv */
`timescale 1ns/100ps
module adc_core_model (
    input wire sys_clk_i,
    input wire conv_req_i,
    input wire [2:0] conv_chan_i,
    input wire slow_i,
    input wire [3:0] tag_i,
    output reg core_done_o,
    output reg [9:0] core_data_o
);
    reg [4:0] wait_q;
    // Idle state of the converter
    initial begin
        core_done_o = 1'b0;
        core_data_o = 10'h155;
        wait_q = 5'h00;
    end
    always @(posedge sys_clk_i) begin
        if (!conv_req_i) begin
            core_done_o <= 1'b0;
            wait_q <= slow_i ? 5'h14 : 5'h02;
            core_data_o <= ~core_data_o; // No stale data when idle
        end else if (wait_q != 5'h00) begin
            wait_q <= wait_q - 5'h01;
        end else begin
            core_done_o <= 1'b1;
            core_data_o <= {tag_i, 3'h0, conv_chan_i};
        end
    end
endmodule

/* File: dv/adc_seq_monitor.sv */
`timescale 1ns/100ps
module adc_seq_monitor #(
    parameter [15:0] STEP_CYCLES = 16'h1F40
) (
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire [5:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [3:0] reg_be_i,
    input wire [31:0] reg_wdata_i,
    input wire [31:0] reg_rdata_o,
    input wire conv_req_o,
    input wire [2:0] conv_chan_o,
    input wire core_done_i,
    input wire [9:0] core_data_i,
    input wire core_reset_o,
    input wire core_power_o,
    input wire oneshot_done_o,
    input wire periodic_done_o
);
    wire ctl_wr = reg_wr_i && reg_addr_i == 6'h00 && reg_be_i[0];
    reg en_q;
    reg [7:0] one_mask_q;
    reg [3:0] idle_q;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // Shadow enable, one-shot mask and cycles without a request
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            en_q <= 1'b0;
            one_mask_q <= 8'h00;
            idle_q <= 4'h0;
        end else begin
            if (ctl_wr)
                en_q <= reg_wdata_i[0];
            if (reg_wr_i && reg_addr_i == 6'h0C && reg_be_i[0])
                one_mask_q <= reg_wdata_i[7:0];
            if (conv_req_o)
                idle_q <= 4'h0;
            else if (idle_q != 4'hF)
                idle_q <= idle_q + 4'h1;
        end
    end
    core_reset_pulse_a: assert property (ctl_wr && reg_wdata_i[0] && !en_q |=> core_reset_o ##1 !core_reset_o)
        else $error("no core reset pulse on enable");
    req_hold_a: assert property (conv_req_o && !core_done_i |=> conv_req_o)
        else $error("request dropped before done");
    done_answer_a: assert property ($rose(core_done_i) && conv_req_o |-> conv_req_o [*3] ##[1:4] !conv_req_o)
        else $error("request not ended after done");
    idle_stop_a: assert property (!en_q && idle_q == 4'hF |-> !conv_req_o)
        else $error("conversion while disabled");
    trig_start_a: assert property (ctl_wr && reg_wdata_i[1:0] == 2'h3 && !reg_wdata_i[4] && one_mask_q != 8'h00
        && idle_q == 4'hF |-> ##[1:6] conv_req_o) else $error("one-shot start delayed");
    rd_upper_zero_a: assert property (reg_rd_i && reg_addr_i >= 6'h14 |=> reg_rdata_o[31:10] == 22'h0)
        else $error("result upper bits not zero");
    one_done_clr_a: assert property (ctl_wr && reg_wdata_i[7] && !reg_wdata_i[1] && oneshot_done_o
        && idle_q == 4'hF |-> ##[1:2] !oneshot_done_o) else $error("one-shot done not cleared");
    one_done_set_a: assert property ($rose(oneshot_done_o) |-> !conv_req_o)
        else $error("one-shot done during conversion");
    per_done_set_a: assert property ($rose(periodic_done_o) |-> !conv_req_o)
        else $error("periodic done during conversion");
    power_busy_a: assert property (conv_req_o |-> core_power_o)
        else $error("core unpowered during conversion");
endmodule

/* File: dv/tb.sv */
`timescale 1ns/100ps
module tb;
    reg sys_clk_i;
    reg reset_n_i;
    reg [5:0] reg_addr_i;
    reg reg_wr_i;
    reg reg_rd_i;
    reg [3:0] reg_be_i;
    reg [31:0] reg_wdata_i;
    wire [31:0] reg_rdata_o;
    wire conv_req_o;
    wire [2:0] conv_chan_o;
    wire core_done_i;
    wire [9:0] core_data_i;
    wire core_reset_o;
    wire core_power_o;
    wire oneshot_done_o;
    wire periodic_done_o;
    wire [2:0] evt = {conv_req_o, periodic_done_o, oneshot_done_o};
    reg slow_q;
    reg [3:0] tag_q;
    reg req_d;
    integer miscompares;
    integer n_tests;
    integer cyc;
    integer n;
    integer i;
    reg [2:0] seen[$];
    adc_conversion_sequencer #(.STEP_CYCLES(16'h0004)) u_adc_conversion_sequencer (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_be_i(reg_be_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .conv_req_o(conv_req_o), .conv_chan_o(conv_chan_o), .core_done_i(core_done_i),
        .core_data_i(core_data_i), .core_reset_o(core_reset_o), .core_power_o(core_power_o),
        .oneshot_done_o(oneshot_done_o), .periodic_done_o(periodic_done_o));
    adc_core_model u_adc_core_model (.sys_clk_i(sys_clk_i), .conv_req_i(conv_req_o), .conv_chan_i(conv_chan_o),
        .slow_i(slow_q), .tag_i(tag_q), .core_done_o(core_done_i), .core_data_o(core_data_i));
    // Clock
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    // Log channel of each new request and bound the run
    always @(posedge sys_clk_i) begin
        req_d <= conv_req_o;
        if (conv_req_o && !req_d)
            seen.push_back(conv_chan_o);
        cyc = cyc + 1;
        if (cyc == 20000) begin
            miscompares = miscompares + 1;
            complete_run;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [5:0] a, input [31:0] d);
        begin
            @(posedge sys_clk_i);
            reg_addr_i <= a;
            reg_wdata_i <= d;
            reg_wr_i <= 1'b1;
            @(posedge sys_clk_i);
            reg_wr_i <= 1'b0;
        end
    endtask
    task rd(input [5:0] a, input [31:0] e);
        begin
            @(posedge sys_clk_i);
            reg_addr_i <= a;
            reg_rd_i <= 1'b1;
            @(posedge sys_clk_i);
            reg_rd_i <= 1'b0;
            @(negedge sys_clk_i);
            chk(reg_rdata_o, e);
        end
    endtask
    task wait_on(input [1:0] s, output integer k);
        begin
            k = 0;
            while (evt[s] !== 1'b1 && k < 3000) begin
                @(negedge sys_clk_i);
                k = k + 1;
            end
        end
    endtask
    task chk_seq(input [31:0] e, input integer cnt);
        begin
            chk(seen.size(), cnt);
            for (i = 0; i < cnt; i = i + 1)
                chk(seen[i], e[4*i +: 3]);
            seen.delete();
        end
    endtask
    task complete_run;
        begin
            $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
            if (miscompares == 0 && n_tests > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        reset_n_i = 1'b0;
        reg_addr_i = 6'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_be_i = 4'hF;
        reg_wdata_i = 32'h0;
        slow_q = 1'b0;
        tag_q = 4'h5;
        req_d = 1'b0;
        miscompares = 0;
        n_tests = 0;
        cyc = 0;
        repeat (16) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        for (i = 0; i < 15; i = i + 1)
            rd({i[3:0], 2'h0}, 32'h0);
        // One-shot pass with delays programmed
        @(posedge sys_clk_i) reg_be_i <= 4'h3;
        wr(6'h04, 32'hFFFF_0005);
        @(posedge sys_clk_i) reg_be_i <= 4'hC;
        wr(6'h04, 32'h0003_FFFF);
        @(posedge sys_clk_i) reg_be_i <= 4'hF;
        rd(6'h04, 32'h0003_0005);
        wr(6'h0C, 32'h0000_00A5);
        wr(6'h00, 32'h0000_0003);
        wait_on(0, n);
        chk_seq(32'h0000_7520, 4);
        rd(6'h00, 32'h0000_0081);
        for (i = 0; i < 8; i = i + 1)
            rd(6'h14 + {1'b0, i[2:0], 2'h0}, ((8'hA5 >> i) & 1) ? {22'h0, tag_q, 3'h0, i[2:0]} : 32'h0);
        rd(6'h08, 32'h0000_00A5);
        wr(6'h08, 32'h0000_0005);
        rd(6'h08, 32'h0000_00A0);
        wr(6'h00, 32'h0000_0089);
        rd(6'h00, 32'h0000_0009);
        // Disable mid-pass, then a trigger while disabled
        tag_q <= 4'h3;
        wr(6'h0C, 32'h0000_00FF);
        wr(6'h00, 32'h0000_0003);
        wait_on(2, n);
        wr(6'h00, 32'h0000_0000);
        repeat (2) @(negedge sys_clk_i);
        chk(core_power_o, 1);
        wait_on(0, n);
        chk_seq(32'h7654_3210, 8);
        rd(6'h30, {22'h0, 4'h3, 6'h07});
        chk(core_power_o, 0);
        wr(6'h00, 32'h0000_0006);
        repeat (200) @(negedge sys_clk_i);
        chk(seen.size(), 0);
        // Periodic passes, slow core, late one-shot with periodic off
        slow_q <= 1'b1;
        tag_q <= 4'hA;
        wr(6'h10, 32'h0000_000C);
        wr(6'h0C, 32'h0000_0001);
        wr(6'h04, 32'h0002_0003);
        wr(6'h00, 32'h0000_0005);
        wait_on(2, n);
        chk(n >= 11 && n <= 24, 1);
        wait_on(1, n);
        wait_on(2, n);
        chk(n >= 7 && n <= 18, 1);
        chk(periodic_done_o, 0);
        wr(6'h00, 32'h0000_0003);
        repeat (300) @(negedge sys_clk_i);
        chk_seq(32'h0000_3232, 5);
        chk({oneshot_done_o, periodic_done_o}, 2'h3);
        rd(6'h14, {22'h0, 4'hA, 6'h00});
        rd(6'h1C, {22'h0, 4'hA, 6'h02});
        complete_run;
    end
endmodule
bind adc_conversion_sequencer adc_seq_monitor #(.STEP_CYCLES(STEP_CYCLES)) u_adc_seq_monitor (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_be_i(reg_be_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .conv_req_o(conv_req_o), .conv_chan_o(conv_chan_o), .core_done_i(core_done_i),
    .core_data_i(core_data_i), .core_reset_o(core_reset_o), .core_power_o(core_power_o),
    .oneshot_done_o(oneshot_done_o), .periodic_done_o(periodic_done_o));
